// file: lpsm_checker.sv
`timescale 1ns/10ps
// Port-level checks on the link power state manager
module lpsm_checker
  import lpsm_pkg::*;
#(
  parameter int TRIM_WIDTH = TRIM_W
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cfg_line_activation_en,
  input wire logic [TRIM_WIDTH-1:0] cfg_max_trim_reduction,
  input wire logic cmd_activate,
  input wire logic line_init_detected,
  input wire logic error_detected,
  input wire logic self_test_done,
  input wire logic high_rate_primitive,
  input wire logic bit_swap_needed,
  input wire logic remote_exit_request,
  input wire logic [7:0] link_state,
  input wire logic start_init,
  input wire logic start_low_power_entry,
  input wire logic start_shutdown,
  input wire logic start_low_power_exit,
  input wire logic start_trim,
  input wire logic [TRIM_WIDTH-1:0] trim_reduction,
  input wire logic tx_enable,
  input wire logic tx_reduced_power,
  input wire logic suppress_category_msgs,
  input wire logic protocol_active,
  input wire logic code_valid
);
  // One clock domain, reset disables every check
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  reset_idle_a: assert property ($fell(reset) |-> link_state == LINK_IDLE && !tx_enable)
    else $error("link not idle after reset");
  tx_cause_a: assert property ($rose(tx_enable) |-> start_init)
    else $error("transmitter woke without init");
  low_outs_a: assert property (tx_reduced_power == (link_state == LINK_LOW_POWER)
    && suppress_category_msgs == tx_reduced_power) else $error("low-power outputs wrong");
  proto_idle_a: assert property (protocol_active == (link_state != LINK_IDLE) && code_valid)
    else $error("protocol activity or code flag wrong");
  activate_idle_a: assert property (cmd_activate && !self_test_done && link_state == LINK_IDLE
    && !tx_enable |=> start_init) else $error("activate ignored in idle");
  line_off_a: assert property (line_init_detected && !cfg_line_activation_en && !cmd_activate
    && link_state == LINK_IDLE && !tx_enable |=> !start_init) else $error("disabled line init");
  error_full_a: assert property (error_detected && !self_test_done && link_state == LINK_FULL_ON
    |=> start_init && link_state == LINK_IDLE) else $error("error not recovered");
  self_test_a: assert property (self_test_done |=> link_state == LINK_IDLE)
    else $error("self test did not set idle");
  exit_cause_a: assert property (start_low_power_exit |-> link_state == LINK_LOW_POWER
    && ($past(high_rate_primitive) || $past(bit_swap_needed) || $past(remote_exit_request)))
    else $error("exit without cause");
  trim_cap_a: assert property (start_trim |-> trim_reduction <= cfg_max_trim_reduction)
    else $error("trim above ceiling");

  // Main scenarios reached
  cover property (start_low_power_entry);
  cover property (start_shutdown);
  cover property ($fell(tx_reduced_power));
endmodule

bind lpsm_link_power_state_manager lpsm_checker #(.TRIM_WIDTH(TRIM_WIDTH)) chk_u (.*);

// file: lpsm_link_power_state_manager.sv
`timescale 1ns/10ps
module lpsm_link_power_state_manager
  import lpsm_pkg::*;
#(
  parameter int RES_WIDTH = RES_W,
  parameter int TRIM_WIDTH = TRIM_W
) (
  input wire logic clock,
  input wire logic reset,
  // Configuration
  input wire logic cfg_line_activation_en,
  input wire logic [RES_WIDTH-1:0] cfg_min_full_on_cycles,
  input wire logic [RES_WIDTH-1:0] cfg_min_low_power_cycles,
  input wire logic [TRIM_WIDTH-1:0] cfg_max_trim_reduction,
  // Higher-layer commands (one-cycle pulses)
  input wire logic cmd_activate,
  input wire logic cmd_enter_low_power,
  input wire logic cmd_shutdown,
  input wire logic cmd_trim,
  input wire logic [TRIM_WIDTH-1:0] cmd_trim_reduction,
  // Local primitives and procedure results (one-cycle pulses)
  input wire logic self_test_done,
  input wire logic line_init_detected,
  input wire logic error_detected,
  input wire logic init_done,
  input wire logic init_failed,
  input wire logic high_rate_primitive,
  input wire logic bit_swap_needed,
  input wire logic exit_done,
  input wire logic exit_failed,
  // Remote transceiver indications
  input wire logic frame_strobe,
  input wire logic remote_lpr_bit,
  input wire logic los_defect,
  input wire logic remote_exit_request,
  input wire logic peer_grant,
  input wire logic peer_reject,
  // Status and control outputs
  output logic [7:0] link_state,
  output logic start_init,
  output logic start_low_power_entry,
  output logic start_shutdown,
  output logic start_low_power_exit,
  output logic start_trim,
  output logic [TRIM_WIDTH-1:0] trim_reduction,
  output logic tx_enable,
  output logic tx_reduced_power,
  output logic suppress_category_msgs,
  output logic protocol_active,
  output logic code_valid
);

  // Link state code for each controller state
  function automatic logic [7:0] state_code(input lpsm_state_t s);
    case (s)
      LPSM_FULL, LPSM_ENTER_LOW, LPSM_SHUTDOWN: state_code = LINK_FULL_ON;
      LPSM_LOW, LPSM_EXIT, LPSM_TRIM: state_code = LINK_LOW_POWER;
      default: state_code = LINK_IDLE;
    endcase
  endfunction

  // True for codes that this controller may legally report
  function automatic logic code_allowed(input logic [7:0] c);
    code_allowed = (c != LINK_RSVD_SINGLE) &&
                   !((c >= LINK_RSVD_LO) && (c <= LINK_RSVD_HI)) &&
                   !((c >= LINK_IMPL_LO) && (c <= LINK_IMPL_HI));
  endfunction

  lpsm_state_t state; // Current controller state
  lpsm_state_t next_state; // Controller state for the next cycle
  logic full_min_reached; // Full-on residency served
  logic low_min_reached; // Low-power residency served
  logic res_restart; // Restart residency on state code change
  logic [1:0] lpr_frames; // Consecutive frames with power loss bit
  logic lpr_armed; // Power loss bit seen often enough
  logic next_start_init; // Pulse values for the next cycle
  logic next_start_entry;
  logic next_start_shutdown;
  logic next_start_exit;
  logic next_start_trim;
  logic [TRIM_WIDTH-1:0] trim_clamped; // Trim amount capped at the limit

  // Residency restarts whenever the reported link state changes
  // Both timers share the restart, so entering low-power starts
  // the trim wait from zero
  assign res_restart = (state_code(next_state) != state_code(state));

  // Full-on minimum residency
  lpsm_residency_timer #(
    .WIDTH(RES_WIDTH)
  ) u_full_timer (
    .clock(clock),
    .reset(reset),
    .restart(res_restart),
    .min_cycles(cfg_min_full_on_cycles),
    .reached(full_min_reached)
  );

  // Low-power minimum residency before a trim
  lpsm_residency_timer #(
    .WIDTH(RES_WIDTH)
  ) u_low_timer (
    .clock(clock),
    .reset(reset),
    .restart(res_restart),
    .min_cycles(cfg_min_low_power_cycles),
    .reached(low_min_reached)
  );

  // Count frames carrying the far-end power loss bit
  // A frame without the bit breaks the run; the count saturates
  // so a lasting loss stays armed until the bit clears
  always_ff @(posedge clock) begin
    if (reset) begin
      lpr_frames <= 2'h0;
    end else if (frame_strobe) begin
      if (!remote_lpr_bit) begin
        lpr_frames <= 2'h0; // Run broken, start over
      end else if (lpr_frames != LPR_MIN_FRAMES) begin
        lpr_frames <= lpr_frames + 2'h1;
      end
    end
  end

  assign lpr_armed = (lpr_frames == LPR_MIN_FRAMES);

  // Requested trim never exceeds the configured ceiling
  // Over-limit requests are clamped rather than refused
  assign trim_clamped = (cmd_trim_reduction > cfg_max_trim_reduction) ?
                        cfg_max_trim_reduction : cmd_trim_reduction;

  // Transition decisions
  // Self-test completion outranks everything; below it each state
  // keeps its own priority, error recovery first except in idle, init and exit, which ignore it
  // Pulses default low so a held state starts nothing
  always_comb begin
    next_state = state;
    next_start_init = 1'b0;
    next_start_entry = 1'b0;
    next_start_shutdown = 1'b0;
    next_start_exit = 1'b0;
    next_start_trim = 1'b0;
    if (self_test_done) begin
      // Self-test completion forces idle from any state
      next_state = LPSM_IDLE;
    end else begin
      case (state)
        LPSM_IDLE: begin
          // Local activate, or line signalling when allowed
          // Activate wins over line signalling in the same cycle
          if (cmd_activate) begin
            next_state = LPSM_INIT;
            next_start_init = 1'b1;
          end else if (line_init_detected && cfg_line_activation_en) begin
            next_state = LPSM_INIT;
            next_start_init = 1'b1;
          end
        end
        LPSM_INIT: begin
          // Link reads idle until initialization finishes
          // A failed initialization drops back to idle
          if (init_done) begin
            next_state = LPSM_FULL;
          end else if (init_failed) begin
            next_state = LPSM_IDLE;
          end
        end
        LPSM_FULL: begin
          // Error recovery restarts initialization at once
          if (error_detected) begin
            next_state = LPSM_INIT;
            next_start_init = 1'b1;
          end else if (lpr_armed && los_defect) begin
            // Far end lost power: no handshake is possible
            next_state = LPSM_IDLE;
          end else if (cmd_shutdown && full_min_reached) begin
            // Shutdown outranks low-power entry
            next_state = LPSM_SHUTDOWN;
            next_start_shutdown = 1'b1;
          end else if (cmd_enter_low_power && full_min_reached) begin
            // Wait in full-on for the peer's answer
            next_state = LPSM_ENTER_LOW;
            next_start_entry = 1'b1;
          end
          // Any other trigger leaves the state alone
        end
        LPSM_ENTER_LOW: begin
          // Low-power entry only on peer grant
          if (error_detected) begin
            next_state = LPSM_INIT;
            next_start_init = 1'b1;
          end else if (peer_grant) begin
            next_state = LPSM_LOW;
          end else if (peer_reject) begin
            next_state = LPSM_FULL;
          end
        end
        LPSM_SHUTDOWN: begin
          // Only a grant completes the orderly shutdown
          if (error_detected) begin
            next_state = LPSM_INIT;
            next_start_init = 1'b1;
          end else if (peer_grant) begin
            next_state = LPSM_IDLE;
          end else if (peer_reject) begin
            next_state = LPSM_FULL;
          end
        end
        LPSM_LOW: begin
          // Error recovery first, then far-end power loss
          if (error_detected) begin
            next_state = LPSM_INIT;
            next_start_init = 1'b1;
          end else if (lpr_armed && los_defect) begin
            next_state = LPSM_IDLE;
          end else if (high_rate_primitive || bit_swap_needed ||
                       remote_exit_request) begin
            // Fast exit ignores the low-power minimum
            next_state = LPSM_EXIT;
            next_start_exit = 1'b1;
          end else if (cmd_trim && low_min_reached) begin
            // Trim waits out the low-power minimum
            next_state = LPSM_TRIM;
            next_start_trim = 1'b1;
          end
        end
        LPSM_EXIT: begin
          // Commit only when the exit procedure succeeds
          // A failed exit keeps the link in low-power
          if (exit_done) begin
            next_state = LPSM_FULL;
          end else if (exit_failed) begin
            next_state = LPSM_LOW;
          end
        end
        LPSM_TRIM: begin
          // Trim grant or reject both stay in low-power
          // Exit triggers may cut a pending trim short
          if (error_detected) begin
            next_state = LPSM_INIT;
            next_start_init = 1'b1;
          end else if (high_rate_primitive || bit_swap_needed ||
                       remote_exit_request) begin
            next_state = LPSM_EXIT;
            next_start_exit = 1'b1;
          end else if (peer_grant || peer_reject) begin
            next_state = LPSM_LOW;
          end
        end
        default: begin
          next_state = LPSM_IDLE;
        end
      endcase
    end
  end

  // Controller state register
  // Reset lands in idle with no procedure running
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= LPSM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Reported link state code
  // Taken from next_state so the code moves at the same edge
  // as the matching start pulse
  always_ff @(posedge clock) begin
    if (reset) begin
      link_state <= LINK_IDLE;
      code_valid <= 1'b1;
    end else begin
      link_state <= state_code(next_state);
      code_valid <= code_allowed(state_code(next_state));
    end
  end

  // Procedure start pulses
  // Each pulse stands for exactly one cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      start_init <= 1'b0;
      start_low_power_entry <= 1'b0;
      start_shutdown <= 1'b0;
      start_low_power_exit <= 1'b0;
      start_trim <= 1'b0;
    end else begin
      start_init <= next_start_init;
      start_low_power_entry <= next_start_entry;
      start_shutdown <= next_start_shutdown;
      start_low_power_exit <= next_start_exit;
      start_trim <= next_start_trim;
    end
  end

  // Trim amount captured with the trim request
  // Held until the next accepted trim
  always_ff @(posedge clock) begin
    if (reset) begin
      trim_reduction <= TRIM_MAX_RST;
    end else if (next_start_trim) begin
      trim_reduction <= trim_clamped;
    end
  end

  // Transmitter and message-layer controls follow the link state
  // Also taken from next_state so they track link_state
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_enable <= 1'b0;
      tx_reduced_power <= 1'b0;
      suppress_category_msgs <= 1'b0;
      protocol_active <= 1'b0;
    end else begin
      // Silent in idle, but initialization needs the line
      tx_enable <= (state_code(next_state) != LINK_IDLE) ||
                   (next_state == LPSM_INIT);
      tx_reduced_power <= (state_code(next_state) == LINK_LOW_POWER);
      suppress_category_msgs <= (state_code(next_state) == LINK_LOW_POWER);
      protocol_active <= (state_code(next_state) != LINK_IDLE);
    end
  end

endmodule

// file: lpsm_peer_model.sv
`timescale 1ns/10ps
// Far-end transceiver: answers requests, sends frames with the power loss bit
module lpsm_peer_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic req,
  input wire logic deny,
  input wire logic [3:0] lag,
  input wire logic [1:0] lpr_req,
  output logic peer_grant,
  output logic peer_reject,
  output logic frame_strobe,
  output logic remote_lpr_bit
);
  logic [4:0] wait_cnt; // Countdown to the answer
  logic [2:0] frame_cnt; // Frame spacing
  logic [1:0] lpr_sent; // Power loss frames sent so far
  // Grant or reject each request after the chosen lag
  always_ff @(posedge clock) begin
    peer_grant <= 1'b0;
    peer_reject <= 1'b0;
    if (reset) begin
      wait_cnt <= 5'h00;
    end else if (req) begin
      wait_cnt <= {1'b0, lag} + 5'h01;
    end else if (wait_cnt == 5'h01) begin
      wait_cnt <= 5'h00;
      peer_grant <= !deny;
      peer_reject <= deny;
    end else if (wait_cnt != 5'h00) begin
      wait_cnt <= wait_cnt - 5'h01;
    end
  end
  // Frame every eight cycles; lpr_req 3 keeps the bit up for good
  always_ff @(posedge clock) begin
    frame_cnt <= reset ? 3'h0 : frame_cnt + 3'h1;
    frame_strobe <= !reset && frame_cnt == 3'h7;
    if (reset || lpr_req == 2'h0) begin
      lpr_sent <= 2'h0;
      remote_lpr_bit <= 1'b0;
    end else if (frame_cnt == 3'h7) begin
      remote_lpr_bit <= lpr_req == 2'h3 || lpr_sent < lpr_req;
      lpr_sent <= (lpr_sent < lpr_req) ? lpr_sent + 2'h1 : lpr_sent;
    end else begin
      remote_lpr_bit <= !remote_lpr_bit; // Meaningless between frames
    end
  end
endmodule

// file: lpsm_pkg.sv
// Shared constants for the link power state manager
package lpsm_pkg;

  // Link state codes, 8-bit code space 0..255
  localparam logic [7:0] LINK_FULL_ON = 8'h00;
  localparam logic [7:0] LINK_LOW_POWER = 8'h02;
  localparam logic [7:0] LINK_IDLE = 8'h03;
  // Reserved block and implementation-specific block bounds
  localparam logic [7:0] LINK_RSVD_SINGLE = 8'h01;
  localparam logic [7:0] LINK_RSVD_LO = 8'h04;
  localparam logic [7:0] LINK_RSVD_HI = 8'h7f;
  localparam logic [7:0] LINK_IMPL_LO = 8'h80;
  localparam logic [7:0] LINK_IMPL_HI = 8'hff;

  // Frames carrying the far-end power loss bit before it counts
  localparam logic [1:0] LPR_MIN_FRAMES = 2'h3;

  // Field widths
  localparam int RES_W = 16;
  localparam int TRIM_W = 8;

  // Reset values of the residency minimums and the trim ceiling
  localparam logic [RES_W-1:0] RES_FULL_MIN_RST = 16'h0000;
  localparam logic [RES_W-1:0] RES_LOW_MIN_RST = 16'h0000;
  localparam logic [TRIM_W-1:0] TRIM_MAX_RST = 8'h00;

  // Controller states
  typedef enum logic [2:0] {
    LPSM_IDLE,
    LPSM_INIT,
    LPSM_FULL,
    LPSM_ENTER_LOW,
    LPSM_SHUTDOWN,
    LPSM_LOW,
    LPSM_EXIT,
    LPSM_TRIM
  } lpsm_state_t;

endpackage

// file: lpsm_residency_timer.sv
`timescale 1ns/10ps
// Counts cycles spent in the current link state and flags the minimum
module lpsm_residency_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic restart,
  input wire logic [WIDTH-1:0] min_cycles,
  output logic reached
);

  logic [WIDTH-1:0] count; // Saturating residency count

  // Count up from a restart, holding at the top value
  always_ff @(posedge clock) begin
    if (reset || restart) begin
      count <= '0;
    end else if (count != {WIDTH{1'b1}}) begin
      count <= count + 1'b1;
    end
  end

  // Registered flag: minimum has been served
  always_ff @(posedge clock) begin
    if (reset || restart) begin
      reached <= 1'b0;
    end else begin
      reached <= (count >= min_cycles);
    end
  end

endmodule

// file: tb.sv
`timescale 1ns/10ps
// Self-checking bench for the link power state manager
module tb;
  import lpsm_pkg::*;
  localparam int ACT = 0, ENT = 1, SHD = 2, TRM = 3, STD = 4, LIN = 5, ERR = 6;
  localparam int IDN = 7, IFL = 8, HRP = 9, BSW = 10, EXD = 11, EXF = 12, REX = 13;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cfg_line_activation_en = 1'b0;
  logic [15:0] cfg_min_full_on_cycles = 16'h0014; // Twenty cycles
  logic [15:0] cfg_min_low_power_cycles = 16'h000a; // Ten cycles
  logic [7:0] cfg_max_trim_reduction = 8'h30;
  logic [7:0] cmd_trim_reduction = 8'h50;
  logic los_defect = 1'b0;
  logic [13:0] pv = 14'h0000; // One bit per pulse input
  logic cmd_activate, cmd_enter_low_power, cmd_shutdown, cmd_trim, self_test_done;
  logic line_init_detected, error_detected, init_done, init_failed, high_rate_primitive;
  logic bit_swap_needed, exit_done, exit_failed, remote_exit_request;
  logic frame_strobe, remote_lpr_bit, peer_grant, peer_reject;
  logic [7:0] link_state, trim_reduction;
  logic start_init, start_low_power_entry, start_shutdown, start_low_power_exit, start_trim;
  logic tx_enable, tx_reduced_power, suppress_category_msgs, protocol_active, code_valid;
  logic deny = 1'b0; // Peer rejects when high
  logic [3:0] lag = 4'h0; // Peer answer delay
  logic [1:0] lpr_req = 2'h0;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  assign {remote_exit_request, exit_failed, exit_done, bit_swap_needed, high_rate_primitive,
    init_failed, init_done, error_detected, line_init_detected, self_test_done, cmd_trim,
    cmd_shutdown, cmd_enter_low_power, cmd_activate} = pv;
  always #12.5 clock = ~clock;
  lpsm_link_power_state_manager dut_u (.*);
  lpsm_peer_model peer_u (.clock(clock), .reset(reset),
    .req(start_low_power_entry | start_shutdown | start_trim), .deny(deny), .lag(lag),
    .lpr_req(lpr_req), .peer_grant(peer_grant), .peer_reject(peer_reject),
    .frame_strobe(frame_strobe), .remote_lpr_bit(remote_lpr_bit));

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle pulse on a chosen input, results visible on return
  task automatic fire(input int idx);
    @(negedge clock);
    pv[idx] = 1'b1;
    @(negedge clock);
    pv = 14'h0000;
  endtask
  task automatic skip(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Bounded wait for a link state code
  task automatic await_state(input logic [7:0] code);
    int n;
    n = 0;
    while (link_state !== code && n < 40) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic bring_up();
    fire(ACT);
    fire(IDN);
  endtask
  task automatic go_low();
    skip(24);
    fire(ENT);
    await_state(LINK_LOW_POWER);
  endtask

  task automatic t_reset();
    check(link_state, LINK_IDLE);
    check({tx_enable, protocol_active, code_valid, trim_reduction}, 11'h100);
    fire(ENT);
    check({start_low_power_entry, link_state}, {1'b0, LINK_IDLE});
    $display("Test reset done");
  endtask
  task automatic t_activate();
    fire(LIN);
    check(start_init, 1'b0);
    cfg_line_activation_en = 1'b1;
    fire(LIN);
    check({start_init, tx_enable}, 2'b11);
    fire(IFL);
    check({tx_enable, link_state}, {1'b0, LINK_IDLE});
    fire(ACT);
    check(start_init, 1'b1);
    fire(IDN);
    check({protocol_active, link_state}, {1'b1, LINK_FULL_ON});
    $display("Test activation done");
  endtask
  task automatic t_entry();
    fire(ENT);
    check(start_low_power_entry, 1'b0);
    skip(24);
    lag = 4'h9;
    fire(ENT);
    check(start_low_power_entry, 1'b1);
    await_state(LINK_LOW_POWER);
    check({tx_reduced_power, suppress_category_msgs, tx_enable, link_state}, 11'h702);
    $display("Test entry done");
  endtask
  task automatic t_trim();
    fire(TRM);
    check(start_trim, 1'b0);
    skip(14);
    fire(TRM);
    check({start_trim, trim_reduction}, 9'h130);
    skip(12);
    cmd_trim_reduction = 8'h10;
    fire(TRM);
    check({trim_reduction, link_state}, {8'h10, LINK_LOW_POWER});
    skip(12);
    $display("Test trim done");
  endtask
  task automatic t_exit();
    int trig[3] = '{HRP, BSW, REX};
    foreach (trig[i]) begin
      fire(trig[i]);
      check({start_low_power_exit, link_state}, {1'b1, LINK_LOW_POWER});
      fire(i == 0 ? EXF : EXD);
      check(link_state, i == 0 ? LINK_LOW_POWER : LINK_FULL_ON);
      if (i == 1) begin
        go_low();
      end
    end
    $display("Test exit done");
  endtask
  task automatic t_error();
    fire(ERR);
    check({start_init, link_state}, {1'b1, LINK_IDLE});
    fire(IDN);
    go_low();
    fire(ERR);
    check({start_init, link_state}, {1'b1, LINK_IDLE});
    fire(IDN);
    fire(STD);
    check({tx_enable, protocol_active, link_state}, {2'b00, LINK_IDLE});
    bring_up();
    $display("Test error done");
  endtask
  task automatic t_shutdown();
    skip(24);
    deny = 1'b1;
    lag = 4'h0;
    fire(SHD);
    check(start_shutdown, 1'b1);
    skip(4);
    check(link_state, LINK_FULL_ON);
    deny = 1'b0;
    fire(SHD);
    check(start_shutdown, 1'b1);
    await_state(LINK_IDLE);
    check({tx_enable, link_state}, {1'b0, LINK_IDLE});
    bring_up();
    $display("Test shutdown done");
  endtask
  task automatic t_power_loss();
    lpr_req = 2'h2;
    skip(40);
    los_defect = 1'b1;
    skip(3);
    check(link_state, LINK_FULL_ON);
    los_defect = 1'b0;
    lpr_req = 2'h0;
    skip(2);
    lpr_req = 2'h3;
    skip(40);
    los_defect = 1'b1;
    skip(3);
    check({tx_enable, link_state}, {1'b0, LINK_IDLE});
    los_defect = 1'b0;
    bring_up();
    go_low();
    check(link_state, LINK_LOW_POWER);
    los_defect = 1'b1;
    skip(2);
    check({tx_reduced_power, link_state}, {1'b0, LINK_IDLE});
    $display("Test power loss done");
  endtask

  // Print counts and the verdict, then stop
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    skip(20);
    reset = 1'b0;
    t_reset();
    t_activate();
    t_entry();
    t_trim();
    t_exit();
    t_error();
    t_shutdown();
    t_power_loss();
    summarize();
  end
endmodule
